/* File: src/gsc_cmd.sv */
// command interpreter: wake, correction period get/set, data checksum
// Function
// - wake word moves sleep to idle; master waits 30 ms afterward.
// - wake word is not acknowledged; master treats that as normal.
// - set-initial word then word plus checksum; stored; 1 ms wait.
// - initial correction period resets to 44 hours.
// - initial period of zero triggers an immediate correction.
// - written periods are volatile until a save command; no save command is decoded here.
// - get-initial word, 1 ms later returns period plus checksum.
// - set-standard word then word plus checksum; 1 ms wait.
// - standard correction period resets to 156 hours.
// - get-standard word, 1 ms later returns period plus checksum.
// - every data word is followed by checksum over its two bytes.
// - command words carry no checksum.
// - checksum poly 0x31, seed 0xff, no reflection, xor 0x00.
module gsc_cmd #(
   parameter int WAKE_CYC = gsc_pkg::WAKE_CYCLES,
   parameter int CMD_CYC  = gsc_pkg::CMD_CYCLES
) (
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        frame_start_in,
   input  wire logic        rx_valid_in,
   input  wire logic [7:0]  rx_byte_in,
   input  wire logic        tx_req_in,
   output logic             rx_ack_out,
   output logic             tx_valid_out,
   output logic      [7:0]  tx_byte_out,
   output logic             busy_out,
   output logic             awake_out,
   output logic      [15:0] init_period_out,
   output logic      [15:0] std_period_out,
   output logic             correct_now_out,
   output logic             crc_err_out
);
   // refuse counts that the 22-bit duration counter cannot hold
   if (WAKE_CYC < 1 || WAKE_CYC >= (1 << gsc_pkg::BUSY_W) || CMD_CYC < 1 ||
       CMD_CYC >= (1 << gsc_pkg::BUSY_W)) begin : g_bad_counts
      $error("gsc_cmd: busy counts out of range");
   end

   gsc_pkg::gsc_state_e state_r;
   logic [15:0] cmd_r;
   logic [7:0]  data_hi_r;
   logic [1:0]  dcnt_r;
   logic [1:0]  tcnt_r;
   logic [21:0] busy_r;
   logic        pend_resp_r;
   logic [15:0] resp_r;
   logic        crc_start;
   logic        crc_step_en;
   logic [7:0]  crc_byte;
   logic [7:0]  crc_val;
   logic        is_wake;
   logic [7:0]  data_lo_r;
   logic [15:0] cmd_word;
   logic        word_end;
   logic        crc_good;

   // checksum as sent: output mask applied to the running value
   function automatic logic [7:0] crc_final(input logic [7:0] c);
      return c ^ gsc_pkg::CRC_XOR_OUT;
   endfunction

   // whole command word as its low byte arrives
   assign cmd_word = {cmd_r[15:8], rx_byte_in};
   assign is_wake  = (cmd_word == gsc_pkg::CMD_WAKE);
   // last byte of a data word is its checksum
   assign word_end = (state_r == gsc_pkg::GSC_DATA) && rx_valid_in && (dcnt_r == 2'd2);
   assign crc_good = (rx_byte_in == crc_final(crc_val));

   // checksum runs over incoming data bytes, and over outgoing word bytes
   assign crc_start = frame_start_in || (state_r == gsc_pkg::GSC_CMD_LO && rx_valid_in)
                      || (state_r == gsc_pkg::GSC_BUSY && busy_r == '0);
   assign crc_step_en = (state_r == gsc_pkg::GSC_DATA && rx_valid_in && dcnt_r != 2'd2)
                      || (state_r == gsc_pkg::GSC_RESP && tx_req_in && tcnt_r != 2'd2);
   assign crc_byte = (state_r == gsc_pkg::GSC_RESP) ? tx_byte_out : rx_byte_in;

   gsc_crc8 u_crc (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .start_in (crc_start),
      .step_in  (crc_step_en),
      .byte_in  (crc_byte),
      .crc_out  (crc_val)
   );

   // sequencing: command bytes, data bytes, command duration, response
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_r     <= gsc_pkg::GSC_SLEEP;
         cmd_r       <= 16'h0000;
         data_hi_r   <= 8'h00;
         dcnt_r      <= 2'd0;
         tcnt_r      <= 2'd0;
         busy_r      <= '0;
         pend_resp_r <= 1'b0;
         awake_out   <= 1'b0;
      end else if (frame_start_in && (state_r == gsc_pkg::GSC_CMD_LO ||
                                      state_r == gsc_pkg::GSC_DATA)) begin
         // a new frame drops a half-received command, else bytes stay misaligned
         state_r <= awake_out ? gsc_pkg::GSC_CMD_HI : gsc_pkg::GSC_SLEEP;
      end else begin
         unique case (state_r)
            gsc_pkg::GSC_SLEEP, gsc_pkg::GSC_CMD_HI: begin
               if (rx_valid_in) begin
                  cmd_r[15:8] <= rx_byte_in;
                  state_r     <= gsc_pkg::GSC_CMD_LO;
               end
            end
            gsc_pkg::GSC_CMD_LO: begin
               if (rx_valid_in) begin
                  cmd_r[7:0] <= rx_byte_in;
                  dcnt_r     <= 2'd0;
                  if (!awake_out) begin
                     // only wake is heard while asleep
                     if (is_wake) begin
                        awake_out <= 1'b1;
                        busy_r    <= gsc_pkg::BUSY_W'(WAKE_CYC - 1);
                        state_r   <= gsc_pkg::GSC_BUSY;
                     end else begin
                        state_r <= gsc_pkg::GSC_SLEEP;
                     end
                  end else if (cmd_word == gsc_pkg::CMD_SET_INIT ||
                               cmd_word == gsc_pkg::CMD_SET_STD) begin
                     state_r <= gsc_pkg::GSC_DATA;
                  end else begin
                     // no checksum follows a command word
                     pend_resp_r <= (cmd_word == gsc_pkg::CMD_GET_INIT) ||
                                    (cmd_word == gsc_pkg::CMD_GET_STD);
                     busy_r  <= gsc_pkg::BUSY_W'(CMD_CYC - 1);
                     state_r <= gsc_pkg::GSC_BUSY;
                  end
               end
            end
            gsc_pkg::GSC_DATA: begin
               if (rx_valid_in) begin
                  dcnt_r <= dcnt_r + 2'd1;
                  if (dcnt_r == 2'd0) begin
                     data_hi_r <= rx_byte_in;
                  end
                  if (dcnt_r == 2'd2) begin
                     pend_resp_r <= 1'b0;
                     busy_r      <= gsc_pkg::BUSY_W'(CMD_CYC - 1);
                     state_r     <= gsc_pkg::GSC_BUSY;
                  end
               end
            end
            gsc_pkg::GSC_BUSY: begin
               // command duration; bytes arriving now are ignored
               if (busy_r != '0) begin
                  busy_r <= busy_r - gsc_pkg::BUSY_W'(1);
               end else begin
                  tcnt_r  <= 2'd0;
                  state_r <= pend_resp_r ? gsc_pkg::GSC_RESP : gsc_pkg::GSC_CMD_HI;
               end
            end
            gsc_pkg::GSC_RESP: begin
               if (tx_req_in) begin
                  tcnt_r <= tcnt_r + 2'd1;
                  if (tcnt_r == 2'd2) begin
                     pend_resp_r <= 1'b0;
                     state_r     <= gsc_pkg::GSC_CMD_HI;
                  end
               end else if (rx_valid_in) begin
                  // master abandoned the read: new command begins
                  cmd_r[15:8] <= rx_byte_in;
                  state_r     <= gsc_pkg::GSC_CMD_LO;
               end
            end
         endcase
      end
   end

   // response word latched when the duration has elapsed
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         resp_r <= 16'h0000;
      end else if (state_r == gsc_pkg::GSC_BUSY && busy_r == '0) begin
         resp_r <= (cmd_r == gsc_pkg::CMD_GET_INIT) ? init_period_out : std_period_out;
      end
   end

   // transmit byte: high, low, then checksum of those two
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         tx_byte_out  <= 8'h00;
         tx_valid_out <= 1'b0;
      end else begin
         // valid drops for a cycle after each take: the checksum is shown
         // only once the low byte has been folded into it
         tx_valid_out <= (state_r == gsc_pkg::GSC_RESP) && !tx_req_in;
         unique case (tcnt_r)
            2'd0:    tx_byte_out <= resp_r[15:8];
            2'd1:    tx_byte_out <= resp_r[7:0];
            default: tx_byte_out <= crc_final(crc_val);
         endcase
         if (state_r == gsc_pkg::GSC_RESP && tx_req_in && tcnt_r == 2'd0) begin
            tx_byte_out <= resp_r[7:0];
         end
      end
   end

   // initial period, volatile: nothing in this block persists it
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         init_period_out <= gsc_pkg::INIT_PERIOD_RST;
         correct_now_out <= 1'b0;
      end else begin
         correct_now_out <= 1'b0;
         if (word_end && crc_good && cmd_r == gsc_pkg::CMD_SET_INIT) begin
            init_period_out <= {data_hi_r, data_lo_r};
            correct_now_out <= ({data_hi_r, data_lo_r} == 16'h0000);
         end
      end
   end

   // standard period, volatile as well
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         std_period_out <= gsc_pkg::STD_PERIOD_RST;
      end else if (word_end && crc_good && cmd_r == gsc_pkg::CMD_SET_STD) begin
         std_period_out <= {data_hi_r, data_lo_r};
      end
   end

   // verdict on the last written word; a bad one leaves the stored value alone
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         crc_err_out <= 1'b0;
      end else if (word_end) begin
         crc_err_out <= !crc_good;
      end
   end

   // low data byte held until the checksum byte arrives and the word is stored
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         data_lo_r <= 8'h00;
      end else if (state_r == gsc_pkg::GSC_DATA && rx_valid_in && dcnt_r == 2'd1) begin
         data_lo_r <= rx_byte_in;
      end
   end

   // acknowledge every byte except while asleep and during any command duration, wake included
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rx_ack_out <= 1'b0;
      end else begin
         rx_ack_out <= rx_valid_in && awake_out && state_r != gsc_pkg::GSC_BUSY;
      end
   end

   // busy flag mirrors the command duration
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         busy_out <= 1'b0;
      end else begin
         busy_out <= (state_r == gsc_pkg::GSC_BUSY) && busy_r != '0;
      end
   end
endmodule

/* File: src/gsc_pkg.sv */
// shared constants for the sensor command interpreter
package gsc_pkg;
   // command words
   localparam logic [15:0] CMD_WAKE      = 16'h36f6;
   localparam logic [15:0] CMD_SET_INIT  = 16'h2445;
   localparam logic [15:0] CMD_GET_INIT  = 16'h2340;
   localparam logic [15:0] CMD_SET_STD   = 16'h244e;
   localparam logic [15:0] CMD_GET_STD   = 16'h234b;
   // checksum
   localparam logic [7:0]  CRC_POLY      = 8'h31;
   localparam logic [7:0]  CRC_INIT      = 8'hff;
   localparam logic [7:0]  CRC_XOR_OUT   = 8'h00;
   // reset values of the correction periods, hours
   localparam logic [15:0] INIT_PERIOD_RST = 16'h002c;
   localparam logic [15:0] STD_PERIOD_RST  = 16'h009c;
   // command durations
   localparam int          CLK_HZ        = 100_000_000;
   localparam int          WAKE_TIME_MS  = 30;
   localparam int          CMD_TIME_MS   = 1;
   localparam int          WAKE_CYCLES   = WAKE_TIME_MS * (CLK_HZ / 1000);
   localparam int          CMD_CYCLES    = CMD_TIME_MS * (CLK_HZ / 1000);
   localparam int          BUSY_W        = 22;
   // interpreter states
   typedef enum logic [2:0] {
      GSC_SLEEP,
      GSC_CMD_HI,
      GSC_CMD_LO,
      GSC_DATA,
      GSC_BUSY,
      GSC_RESP
   } gsc_state_e;
endpackage

/* File: src/gsc_crc8.sv */
// one-byte step of the 8-bit data checksum, registered result
module gsc_crc8 (
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       start_in,
   input  wire logic       step_in,
   input  wire logic [7:0] byte_in,
   output logic      [7:0] crc_out
);
   // msb first, no reflection, polynomial feed per bit
   function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] b);
      logic [7:0] r;
      r = c ^ b;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ((r << 1) ^ gsc_pkg::CRC_POLY) : (r << 1);
      end
      return r;
   endfunction

   // start restores the seed, so each word is checksummed alone
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || start_in) begin
         crc_out <= gsc_pkg::CRC_INIT;
      end else if (step_in) begin
         crc_out <= crc_step(crc_out, byte_in);
      end
   end
endmodule

/* File: bench/gsc_cmd_chk.sv */
// port checker for the sensor command interpreter
module gsc_cmd_chk #(
   parameter int WAKE_CYC = 20,
   parameter int CMD_CYC  = 10
) (
   input wire logic        clk_in,
   input wire logic        rst_n_in,
   input wire logic        frame_start_in,
   input wire logic        rx_valid_in,
   input wire logic [7:0]  rx_byte_in,
   input wire logic        tx_req_in,
   input wire logic        rx_ack_out,
   input wire logic        tx_valid_out,
   input wire logic [7:0]  tx_byte_out,
   input wire logic        busy_out,
   input wire logic        awake_out,
   input wire logic [15:0] init_period_out,
   input wire logic [15:0] std_period_out,
   input wire logic        correct_now_out,
   input wire logic        crc_err_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] busy_cnt_r;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // length of the running busy stretch, so a stuck timer shows
   always_ff @(posedge clk_in) begin
      busy_cnt_r <= (!rst_n_in || !busy_out) ? 32'h0 : busy_cnt_r + 32'h1;
   end
   chk_sleep_no_ack: assert property (rx_valid_in && !awake_out |=> !rx_ack_out)
      else $error("byte acked while asleep");
   chk_idle_ack: assert property (rx_valid_in && awake_out && !busy_out |=> rx_ack_out)
      else $error("byte not acked while idle");
   chk_busy_no_ack: assert property (rx_valid_in && busy_out |=> !rx_ack_out)
      else $error("byte acked while busy");
   chk_busy_bound: assert property (busy_cnt_r <= WAKE_CYC + CMD_CYC + 4)
      else $error("busy lasts too long");
   chk_stay_awake: assert property (awake_out |=> awake_out)
      else $error("idle state lost");
   chk_init_rst: assert property ($rose(rst_n_in) |-> init_period_out == 16'h002c)
      else $error("initial period reset value wrong");
   chk_std_rst: assert property ($rose(rst_n_in) |-> std_period_out == 16'h009c)
      else $error("standard period reset value wrong");
   chk_zero_period: assert property (correct_now_out |-> ##[0:1] init_period_out == 16'h0000)
      else $error("correction without zero period");
   chk_zero_pulse: assert property (correct_now_out |=> !correct_now_out)
      else $error("correction pulse too long");
   chk_tx_hold: assert property (tx_valid_out && !tx_req_in |=> tx_valid_out && $stable(tx_byte_out))
      else $error("response byte not held");
   chk_write_busy: assert property ($changed(init_period_out) || $changed(std_period_out)
      |=> busy_out)
      else $error("period changed outside a command");
   cov_fix: cover property ($rose(correct_now_out));
   cov_bad: cover property ($rose(crc_err_out));
   cov_read: cover property (tx_valid_out && tx_req_in);
endmodule

/* File: bench/gsc_mst_model.sv */
// two-wire bus master model issuing sensor commands
module gsc_mst_model (
   input  wire logic       clk_in,
   input  wire logic       tx_valid_in,
   input  wire logic [7:0] tx_byte_in,
   output logic            frame_start_out,
   output logic            rx_valid_out,
   output logic      [7:0] rx_byte_out,
   output logic            tx_req_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle bus at time zero
   initial begin
      frame_start_out = 1'b0;
      rx_valid_out    = 1'b0;
      rx_byte_out     = 8'h00;
      tx_req_out      = 1'b0;
   end
   // bitwise form of the bytewise checksum, high byte first
   function automatic logic [7:0] crc8(input logic [15:0] w);
      logic [7:0] c;
      c = 8'hff;
      for (int i = 15; i >= 0; i--) begin
         c = (c[7] ^ w[i]) ? ((c << 1) ^ 8'h31) : (c << 1);
      end
      return c;
   endfunction
   // no ack is awaited, a missing one is normal
   task automatic put(input logic [7:0] b);
      @(posedge clk_in);
      rx_byte_out  <= b;
      rx_valid_out <= 1'b1;
      @(posedge clk_in);
      rx_valid_out <= 1'b0;
      rx_byte_out  <= ~b; // released lane must not keep the last byte
   endtask
   task automatic cmd(input logic [15:0] w);
      @(posedge clk_in);
      frame_start_out <= 1'b1;
      @(posedge clk_in);
      frame_start_out <= 1'b0;
      put(w[15:8]);
      put(w[7:0]);
   endtask
   // data word then its checksum, optionally spoiled
   task automatic word(input logic [15:0] v, input logic bad);
      put(v[15:8]);
      put(v[7:0]);
      put(crc8(v) ^ {7'h00, bad});
   endtask
   // wait for a response byte, then take it with one request pulse
   task automatic take();
      int n;
      n = 0;
      @(posedge clk_in);
      while (!tx_valid_in && n < 200) begin
         @(posedge clk_in);
         n++;
      end
      tx_req_out <= 1'b1;
      @(posedge clk_in);
      tx_req_out <= 1'b0;
      @(posedge clk_in);
   endtask
endmodule

/* File: bench/gsc_cmd_tb_top.sv */
// self-checking bench for the sensor command interpreter
module gsc_cmd_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WAKE_C = 20;
   localparam int CMD_C  = 10;
   logic        clk_in, rst_n_in, fs, rxv, txr, ack, txv, busy, awake, corr, crc_err;
   logic [7:0]  rxb, txb;
   logic [15:0] init_p, std_p, val;
   logic [7:0]  exp_q[$];
   int          n_fail = 0;
   int          checks = 0;
   int          n_corr = 0;
   int          seed   = 32'h568d;
   gsc_cmd #(.WAKE_CYC(WAKE_C), .CMD_CYC(CMD_C)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .frame_start_in(fs), .rx_valid_in(rxv), .rx_byte_in(rxb), .tx_req_in(txr),
      .rx_ack_out(ack), .tx_valid_out(txv), .tx_byte_out(txb), .busy_out(busy),
      .awake_out(awake), .init_period_out(init_p), .std_period_out(std_p),
      .correct_now_out(corr), .crc_err_out(crc_err));
   gsc_mst_model u_mst (.clk_in(clk_in), .tx_valid_in(txv), .tx_byte_in(txb),
      .frame_start_out(fs), .rx_valid_out(rxv), .rx_byte_out(rxb), .tx_req_out(txr));
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   task automatic cmp_val(input string what, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s exp %h got %h", what, e, g);
      end
   endtask
   task automatic cmp_byte(input string what, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s exp %h got %h", what, e, g);
      end
   endtask
   task automatic print_verdict();
      if (n_fail == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // taken response bytes against the oldest note
   always @(posedge clk_in) begin
      if (txr && txv) cmp_byte("tx_byte", (exp_q.size() != 0) ? exp_q.pop_front() : 8'hxx, txb);
      if (rst_n_in && corr) n_corr <= n_corr + 1;
   end
   // write, poke during busy, then read back with checksum
   task automatic set_get(input logic [15:0] sc, gc, v, input logic [7:0] c);
      u_mst.cmd(sc);
      u_mst.word(v, 1'b0);
      u_mst.put(8'h00);
      repeat (CMD_C + 4) @(posedge clk_in);
      cmp_val("period", v, (sc == gsc_pkg::CMD_SET_INIT) ? init_p : std_p);
      exp_q.push_back(v[15:8]);
      exp_q.push_back(v[7:0]);
      exp_q.push_back(c);
      u_mst.cmd(gc);
      repeat (3) u_mst.take();
   endtask
   initial begin
      rst_n_in = 1'b0;
      repeat (12) @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(posedge clk_in);
      cmp_val("init_rst", 16'h002c, init_p);
      cmp_val("std_rst", 16'h009c, std_p);
      u_mst.cmd(gsc_pkg::CMD_SET_INIT);
      u_mst.word(16'h0010, 1'b0);
      repeat (CMD_C + 4) @(posedge clk_in);
      cmp_val("asleep", 16'h002c, init_p);
      u_mst.cmd(gsc_pkg::CMD_WAKE);
      repeat (WAKE_C + 4) @(posedge clk_in);
      cmp_val("awake", 16'h0001, {15'h0000, awake});
      set_get(gsc_pkg::CMD_SET_INIT, gsc_pkg::CMD_GET_INIT, 16'h004c, 8'hc1);
      set_get(gsc_pkg::CMD_SET_STD, gsc_pkg::CMD_GET_STD, 16'h009c, 8'hc5);
      for (int i = 0; i < 4; i++) begin
         val = 16'($random(seed)) & 16'hfffc;
         set_get((i % 2) ? gsc_pkg::CMD_SET_STD : gsc_pkg::CMD_SET_INIT,
            (i % 2) ? gsc_pkg::CMD_GET_STD : gsc_pkg::CMD_GET_INIT, val, u_mst.crc8(val));
      end
      // val still holds the standard period written last by the loop
      u_mst.cmd(gsc_pkg::CMD_SET_STD);
      u_mst.word(val ^ 16'h0040, 1'b1);
      repeat (CMD_C + 4) @(posedge clk_in);
      cmp_val("crc_err", 16'h0001, {15'h0000, crc_err});
      cmp_val("bad_kept", val, std_p);
      set_get(gsc_pkg::CMD_SET_INIT, gsc_pkg::CMD_GET_INIT, 16'h0000, u_mst.crc8(16'h0000));
      cmp_val("crc_ok", 16'h0000, {15'h0000, crc_err});
      cmp_val("correct", 16'h0001, n_corr[15:0]);
      rst_n_in <= 1'b0;
      repeat (12) @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(posedge clk_in);
      cmp_val("init_rst2", 16'h002c, init_p);
      cmp_val("std_rst2", 16'h009c, std_p);
      cmp_val("queue", 16'h0000, 16'(exp_q.size()));
      print_verdict();
   end
   // cut a hang short well beyond the expected run
   initial begin
      repeat (4000) @(posedge clk_in);
      n_fail++;
      print_verdict();
   end
endmodule
bind gsc_cmd gsc_cmd_chk #(.WAKE_CYC(WAKE_CYC), .CMD_CYC(CMD_CYC)) u_chk (.clk_in(clk_in),
   .rst_n_in(rst_n_in), .frame_start_in(frame_start_in), .rx_valid_in(rx_valid_in),
   .rx_byte_in(rx_byte_in), .tx_req_in(tx_req_in), .rx_ack_out(rx_ack_out),
   .tx_valid_out(tx_valid_out), .tx_byte_out(tx_byte_out), .busy_out(busy_out),
   .awake_out(awake_out), .init_period_out(init_period_out), .std_period_out(std_period_out),
   .correct_now_out(correct_now_out), .crc_err_out(crc_err_out));
